// ### bench/fob_exec_tb_top.sv
// Self-checking testbench of the execution block
`timescale 1ns/1ps
`default_nettype none
module fob_exec_tb_top;
  import fob_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, instr_valid = 1'b0, file_we, w_we, z_we, z_val;
  logic pc_load, flush, busy;
  logic [FOB_IW-1:0] instr = 12'h000;
  logic [FOB_DW-1:0] file_rdata, status_in = 8'h00, file_wdata, w_wdata;
  logic [FOB_AW-1:0] file_addr;
  logic [FOB_PCW-1:0] pc_target;
  int err_total = 0, compares = 0;
  logic [11:0] instr_last;
  fob_exec fob_exec_inst (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .status_in(status_in), .file_addr(file_addr),
    .file_wdata(file_wdata), .file_we(file_we), .w_wdata(w_wdata), .w_we(w_we),
    .z_we(z_we), .z_val(z_val), .pc_load(pc_load), .pc_target(pc_target),
    .flush(flush), .busy(busy));
  fob_file_model fob_file_model_inst (.mclk(mclk), .rd_addr(instr[4:0]), .rdata(file_rdata),
    .we(file_we), .wr_addr(file_addr), .wdata(file_wdata));
  initial begin
    forever #2 mclk = ~mclk;
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input logic v, input logic [11:0] i);
    @(posedge mclk);
    instr_valid <= v;
    instr <= i;
    #1;
  endtask
  task automatic run(input logic [11:0] i, input logic [7:0] fv);
    fob_file_model_inst.mem[i[4:0]] = fv;
    step(1'b1, i);
    step(1'b0, 12'h000);
  endtask
  task automatic res(input logic w, f, zw, zv, fl, input logic [7:0] d);
    chk("w_we", w_we, w);
    chk("file_we", file_we, f);
    chk("z_we", z_we, zw);
    chk("flush", flush, fl);
    chk("busy", busy, fl);
    chk("pc_load", pc_load, 1'b0);
    if (zw) chk("z_val", z_val, zv);
    if (w) chk("w_wdata", w_wdata, d);
    if (f) chk("file_wdata", file_wdata, d);
    if (f) chk("file_addr", file_addr, instr_last[4:0]);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_complement();
    instr_last = 12'h243;
    run(12'h243, 8'h13);
    res(1, 0, 1, 0, 0, ~8'h13);
    instr_last = 12'h264;
    run(12'h264, 8'hFF);
    res(0, 1, 1, 1, 0, 8'h00);
  endtask
  task automatic t_decrement();
    instr_last = 12'h0C5;
    run(12'h0C5, 8'h01);
    res(1, 0, 1, 1, 0, 8'h00);
    instr_last = 12'h0E6;
    run(12'h0E6, 8'h00);
    res(0, 1, 1, 0, 0, 8'hFF);
  endtask
  task automatic t_skip();
    instr_last = 12'h2E7;
    fob_file_model_inst.mem[7] = 8'h01;
    step(1'b1, 12'h2E7);
    step(1'b1, 12'h243);
    res(0, 1, 0, 0, 1, 8'h00);
    step(1'b0, 12'h000);
    res(0, 0, 0, 0, 0, 8'h00);
    instr_last = 12'h2C8;
    run(12'h2C8, 8'h02);
    res(1, 0, 0, 0, 0, 8'h01);
  endtask
  task automatic t_branch(input logic [7:0] st, input logic [11:0] i);
    @(posedge mclk);
    status_in <= st;
    run(i, 8'h00);
    chk("pc_load", pc_load, 1'b1);
    chk("pc_target", pc_target, {st[6:5], i[8:0]});
    chk("flush", flush, 1'b1);
    chk("w_we", w_we, 1'b0);
  endtask
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_complement();
    t_decrement();
    t_skip();
    t_branch(8'h60, 12'hA05);
    t_branch(8'h20, 12'hBFF);
    give_verdict();
  end
endmodule // fob_exec_tb_top
`default_nettype wire

// ### bench/fob_file_model.sv
// File register array model facing the execution block
`timescale 1ns/1ps
`default_nettype none
module fob_file_model
  import fob_pkg::*;
(
  input wire logic mclk,
  input wire logic [FOB_AW-1:0] rd_addr,
  output logic [FOB_DW-1:0] rdata,
  input wire logic we,
  input wire logic [FOB_AW-1:0] wr_addr,
  input wire logic [FOB_DW-1:0] wdata
);
  logic [FOB_DW-1:0] mem [32];
  assign rdata = mem[rd_addr];
  always @(posedge mclk) begin
    if (we) begin
      mem[wr_addr] <= wdata;
    end
  end
endmodule // fob_file_model
`default_nettype wire

// ### rtl/fob_decode.sv
// Instruction word decoder for the four supported operations
`timescale 1ns/1ps
`default_nettype none
module fob_decode
  import fob_pkg::*;
(
  input wire logic [FOB_IW-1:0] instr,
  output var fob_op_e op
);
  always_comb begin
    op = FOB_NONE;
    if (instr[FOB_IW-1:FOB_OPC3_LSB] == FOB_OPC_BRANCH) begin
      op = FOB_BRANCH;
    end else if (instr[FOB_IW-1:FOB_OPC6_LSB] == FOB_OPC_COMPLEMENT) begin
      op = FOB_COMPLEMENT;
    end else if (instr[FOB_IW-1:FOB_OPC6_LSB] == FOB_OPC_DECREMENT) begin
      op = FOB_DECREMENT;
    end else if (instr[FOB_IW-1:FOB_OPC6_LSB] == FOB_OPC_DEC_SKIP) begin
      op = FOB_DEC_SKIP;
    end
  end
endmodule // fob_decode
`default_nettype wire

// ### rtl/fob_exec.sv
// Execution unit for complement, decrement, decrement-skip and branch
`timescale 1ns/1ps
`default_nettype none
module fob_exec
  import fob_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [FOB_IW-1:0] instr,
  input wire logic [FOB_DW-1:0] file_rdata,
  input wire logic [FOB_DW-1:0] status_in,
  output logic [FOB_AW-1:0] file_addr,
  output logic [FOB_DW-1:0] file_wdata,
  output logic file_we,
  output logic [FOB_DW-1:0] w_wdata,
  output logic w_we,
  output logic z_we,
  output logic z_val,
  output logic pc_load,
  output logic [FOB_PCW-1:0] pc_target,
  output logic flush,
  output logic busy
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [FOB_AW-1:0] addr;
    logic [FOB_DW-1:0] fdata;
    logic fwe;
    logic [FOB_DW-1:0] wdata;
    logic wwe;
    logic zwe;
    logic zval;
    logic pcl;
    logic [FOB_PCW-1:0] pct;
    logic flush;
    logic busy;
  } fob_st_s;

  fob_st_s st_q, st_d;
  fob_op_e op;
  logic [FOB_DW-1:0] res;
  logic dest_file;

  function automatic logic fob_is_zero(input logic [FOB_DW-1:0] v);
    return v == FOB_ZERO_RST;
  endfunction

  fob_decode fob_decode_inst (
    .instr(instr),
    .op(op)
  );

  // ************************************************************
  // Execute
  // ************************************************************
  always_comb begin
    st_d = st_q;
    st_d.fwe = 1'b0;
    st_d.wwe = 1'b0;
    st_d.zwe = 1'b0;
    st_d.pcl = 1'b0;
    st_d.flush = 1'b0;
    st_d.busy = 1'b0;
    dest_file = instr[FOB_DEST_BIT];
    res = file_rdata - 8'h01;
    // A flush cycle is the discarded prefetch: execute nothing
    if (instr_valid && !st_q.flush) begin
      st_d.addr = instr[FOB_AW-1:0];
      unique case (op)
        FOB_COMPLEMENT: begin
          res = ~file_rdata;
        end
        default: begin
        end
      endcase
      st_d.fdata = res;
      st_d.wdata = res;
      st_d.zval = fob_is_zero(res);
      if (op == FOB_COMPLEMENT || op == FOB_DECREMENT || op == FOB_DEC_SKIP) begin
        st_d.fwe = dest_file;
        st_d.wwe = !dest_file;
      end
      // zero update; decrement-skip keeps flags; zero test
      st_d.zwe = (op == FOB_COMPLEMENT || op == FOB_DECREMENT);
      // skip on zero; no flush for plain ops
      if (op == FOB_DEC_SKIP && fob_is_zero(res)) begin
        st_d.flush = 1'b1;
        st_d.busy = 1'b1;
      end
      if (op == FOB_BRANCH) begin
        st_d.pct = {status_in[FOB_STAT_PAGE_LSB+:FOB_STAT_PAGE_W], instr[FOB_K_W-1:0]};
        st_d.pcl = 1'b1;
        st_d.flush = 1'b1;
        st_d.busy = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign file_addr = st_q.addr;
  assign file_wdata = st_q.fdata;
  assign file_we = st_q.fwe;
  assign w_wdata = st_q.wdata;
  assign w_we = st_q.wwe;
  assign z_we = st_q.zwe;
  assign z_val = st_q.zval;
  assign pc_load = st_q.pcl;
  assign pc_target = st_q.pct;
  assign flush = st_q.flush;
  assign busy = st_q.busy;

  // ************************************************************
  // Checks
  // ************************************************************
  logic take;
  assign take = instr_valid && !flush;

  AST_CPL_VAL: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_COMPLEMENT |=> file_wdata == ~$past(file_rdata) && z_we)
    else $error("complement result wrong");

  AST_CPL_ZERO: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_COMPLEMENT |=> z_val == ($past(file_rdata) == 8'hFF))
    else $error("complement zero flag wrong");

  AST_CPL_DEST: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_COMPLEMENT |=>
      file_we == $past(instr[FOB_DEST_BIT]) && w_we != file_we)
    else $error("complement destination wrong");

  AST_DEST: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_DECREMENT |=>
      file_we == $past(instr[FOB_DEST_BIT]) && w_we != file_we)
    else $error("destination select wrong");

  AST_DEC_VAL: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_DECREMENT |=> w_wdata == $past(file_rdata) - 8'h01 && z_we)
    else $error("decrement result wrong");

  AST_DEC_ZERO: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_DECREMENT |=> z_val == ($past(file_rdata) == 8'h01))
    else $error("decrement zero flag wrong");

  AST_DSZ_FLAGS: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_DEC_SKIP |=> !z_we)
    else $error("skip op touched flags");

  AST_DSZ_VAL: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_DEC_SKIP |=>
      (file_we ? file_wdata : w_wdata) == $past(file_rdata) - 8'h01)
    else $error("skip op result wrong");

  AST_DSZ_DEST: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_DEC_SKIP |=>
      file_we == $past(instr[FOB_DEST_BIT]) && w_we != file_we)
    else $error("skip op destination wrong");

  AST_SKIP: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_DEC_SKIP |=> flush == ($past(file_rdata) == 8'h01))
    else $error("skip decision wrong");

  AST_IDLE: assert property (@(posedge mclk) disable iff (rst)
    !take |=> !file_we && !w_we && !z_we && !pc_load && !flush)
    else $error("ignored slot produced output");

  AST_TARGET: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_BRANCH |=> pc_load && pc_target == {$past(status_in[6:5]),
      $past(instr[8:0])})
    else $error("branch target wrong");

  AST_PAGE: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_BRANCH |=> pc_target[10:9] == $past(status_in[6:5]))
    else $error("branch page bits wrong");

  AST_BR_TWO: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_BRANCH |=> flush ##1 !flush && !pc_load)
    else $error("branch not two cycles");

  AST_BR_QUIET: assert property (@(posedge mclk) disable iff (rst)
    take && op == FOB_BRANCH |=> !file_we && !w_we && !z_we)
    else $error("branch wrote a register");

  AST_PLAIN: assert property (@(posedge mclk) disable iff (rst)
    take && (op == FOB_COMPLEMENT || op == FOB_DECREMENT) |=> !flush && !busy)
    else $error("plain op flushed");

  AST_ZERO: assert property (@(posedge mclk) disable iff (rst)
    z_we |-> z_val == (w_we ? w_wdata == 8'h00 : file_wdata == 8'h00))
    else $error("zero flag wrong");

  // ************************************************************
  // Coverage
  // ************************************************************
  COV_SKIP: cover property (@(posedge mclk) disable iff (rst)
    take && op == FOB_DEC_SKIP ##1 flush);
  COV_NO_SKIP: cover property (@(posedge mclk) disable iff (rst)
    take && op == FOB_DEC_SKIP ##1 !flush);
  COV_BRANCH: cover property (@(posedge mclk) disable iff (rst) pc_load);
  COV_ZERO: cover property (@(posedge mclk) disable iff (rst) z_we && z_val);
  COV_FILE_WB: cover property (@(posedge mclk) disable iff (rst) file_we && z_we);
endmodule // fob_exec
`default_nettype wire

// ### rtl/fob_pkg.sv
// Constants and types for the file-operation and branch execution block
`default_nettype none
package fob_pkg;
  localparam int FOB_IW = 12;
  localparam int FOB_DW = 8;
  localparam int FOB_AW = 5;
  localparam int FOB_PCW = 11;
  // Opcode fields
  localparam logic [5:0] FOB_OPC_COMPLEMENT = 6'h09;
  localparam logic [5:0] FOB_OPC_DECREMENT = 6'h03;
  localparam logic [5:0] FOB_OPC_DEC_SKIP = 6'h0B;
  localparam logic [2:0] FOB_OPC_BRANCH = 3'h5;
  localparam int FOB_OPC6_LSB = 6;
  localparam int FOB_OPC3_LSB = 9;
  localparam int FOB_DEST_BIT = 5;
  localparam int FOB_K_W = 9;
  localparam int FOB_STAT_PAGE_LSB = 5;
  localparam int FOB_STAT_PAGE_W = 2;
  localparam logic [FOB_DW-1:0] FOB_ZERO_RST = 8'h00;
  typedef enum logic [2:0] {
    FOB_NONE, FOB_COMPLEMENT, FOB_DECREMENT, FOB_DEC_SKIP, FOB_BRANCH
  } fob_op_e;
endpackage : fob_pkg
`default_nettype wire
